// ==== src/branch_pkg.sv ====
// constants and types shared by the conditional branch decode logic
package branch_pkg;
   localparam int WORD_W  = 16;
   localparam int PC_W    = 21;
   localparam int OFF_W   = 8;
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 8;
   localparam int OFF_MSB = 7;
   localparam int OFF_LSB = 0;
   localparam int NUM_KIND = 3;
   localparam int KIND_CARRY = 0;
   localparam int KIND_NEG   = 1;
   localparam int KIND_OVF   = 2;

   // upper-byte encodings of the three branch forms
   localparam logic [OFF_W-1:0] OPC_CARRY_CLR = 8'hE3;
   localparam logic [OFF_W-1:0] OPC_NEG_CLR   = 8'hE7;
   localparam logic [OFF_W-1:0] OPC_OVF_CLR   = 8'hE5;
   localparam logic [NUM_KIND*OFF_W-1:0] OPC_TABLE =
      {OPC_OVF_CLR, OPC_NEG_CLR, OPC_CARRY_CLR};

   // quarter-cycle phase numbers, one clock each
   localparam logic [1:0] PH_Q1   = 2'h0;
   localparam logic [1:0] PH_Q2   = 2'h1;
   localparam logic [1:0] PH_Q3   = 2'h2;
   localparam logic [1:0] PH_Q4   = 2'h3;
   localparam logic [1:0] PH_STEP = 2'h1;

   localparam logic [PC_W-1:0]   PC_RST   = 21'h000000;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [OFF_W-1:0]  OFF_RST  = 8'h00;

   typedef enum logic [2:0] {
      S_IDLE, S_DEC, S_LIT, S_PROC, S_WRITE, S_NOP
   } state_t;
endpackage

// ==== src/match_if.sv ====
// bundle between the core sequencer and the opcode matcher
`timescale 1ns/10ps
interface match_if;
   logic [branch_pkg::WORD_W-1:0] word;
   logic                          carryFlag;
   logic                          negFlag;
   logic                          ovfFlag;
   logic                          hit;
   logic                          condClear;

   modport dec  (input word, carryFlag, negFlag, ovfFlag,
                 output hit, condClear);
   modport core (output word, carryFlag, negFlag, ovfFlag,
                 input hit, condClear);
endinterface

// ==== src/branch_match.sv ====
// opcode matcher: spots the three clear-flag branches and tests their flag
`timescale 1ns/10ps
module branch_match (
   match_if.dec m
);
   logic [branch_pkg::NUM_KIND-1:0] flagVec;
   logic [branch_pkg::NUM_KIND-1:0] kindHit;

   // flag order follows the opcode table
   assign flagVec[branch_pkg::KIND_CARRY] = m.carryFlag;
   assign flagVec[branch_pkg::KIND_NEG]   = m.negFlag;
   assign flagVec[branch_pkg::KIND_OVF]   = m.ovfFlag;

   // one comparator per table entry; only the upper byte is compared
   for (genvar k = 0; k < branch_pkg::NUM_KIND; k++) begin : g_kind
      assign kindHit[k] =
         m.word[branch_pkg::OPC_MSB:branch_pkg::OPC_LSB] ==
         branch_pkg::OPC_TABLE[k*branch_pkg::OFF_W +: branch_pkg::OFF_W];
   end

   assign m.hit       = |kindHit;
   // branch condition is the tested flag being zero
   assign m.condClear = |(kindHit & ~flagVec);
endmodule

// ==== src/conditional_branch_decode.sv ====
// sequencer for short relative branches that test a cleared status flag
`timescale 1ns/10ps
// Summary of operation
// - upper byte E3 is branch on carry clear, taken only if carry is zero
// - upper byte E7 is branch on negative clear, taken only if negative zero
// - upper byte E5 is branch on overflow clear, taken only if overflow zero
// - taken branch loads incremented fetch address plus twice the offset
// - low byte is a signed offset, -128 to 127, doubled before adding
// - one word; one instruction cycle not taken, two cycles taken
// - taken: decode, literal, process, write pc, then four idle phases
// - not taken: decode, literal, process, idle fourth phase, pc kept
// - no status flag is written by these branches
module conditional_branch_decode (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   input  wire logic                          clkEn,
   input  wire logic                          instrValid,
   input  wire logic [branch_pkg::WORD_W-1:0] instrWord,
   input  wire logic [branch_pkg::PC_W-1:0]   pcIn,
   input  wire logic                          carryFlag,
   input  wire logic                          negFlag,
   input  wire logic                          ovfFlag,
   output logic                               readyQ,
   output logic                               busyQ,
   output logic [1:0]                         phaseQ,
   output logic                               pcWeQ,
   output logic [branch_pkg::PC_W-1:0]        pcNextQ,
   output logic                               takenQ,
   output logic                               flushQ,
   output logic                               doneQ,
   output logic                               flagsWeQ
);
   branch_pkg::state_t              stateQ, stateD;
   logic [branch_pkg::WORD_W-1:0]   instrQ, instrD;
   logic [branch_pkg::PC_W-1:0]     baseQ, baseD;
   logic [branch_pkg::OFF_W-1:0]    litQ, litD;
   logic [branch_pkg::PC_W-1:0]     pcNextD;
   logic [branch_pkg::PC_W-1:0]     offsetX2;
   logic [1:0]                      phaseD;
   logic                            readyD, busyD, pcWeD, takenD;
   logic                            flushD, doneD;

   match_if mif ();

   branch_match u_match (
      .m (mif)
   );

   // while idle the matcher looks at the offered word, later at the held one
   assign mif.word      = (stateQ == branch_pkg::S_IDLE) ? instrWord : instrQ;
   assign mif.carryFlag = carryFlag;
   assign mif.negFlag   = negFlag;
   assign mif.ovfFlag   = ovfFlag;

   // sign-extend the literal and double it by a one-bit shift
   assign offsetX2 = {{(branch_pkg::PC_W-branch_pkg::OFF_W-1){litQ[
                       branch_pkg::OFF_MSB]}}, litQ, 1'b0};

   // next-state logic of the phase sequencer
   always_comb begin
      stateD  = stateQ;
      instrD  = instrQ;
      baseD   = baseQ;
      litD    = litQ;
      pcNextD = pcNextQ;
      phaseD  = phaseQ;
      readyD  = readyQ;
      busyD   = busyQ;
      takenD  = takenQ;
      flushD  = flushQ;
      pcWeD   = 1'b0;
      doneD   = 1'b0;
      unique case (stateQ)
         branch_pkg::S_IDLE: begin
            // words that are not one of ours are left to other decoders
            if (instrValid && mif.hit) begin
               instrD = instrWord;
               baseD  = pcIn; // already the address of the next word
               stateD = branch_pkg::S_DEC;
               phaseD = branch_pkg::PH_Q1;
               readyD = 1'b0;
               busyD  = 1'b1;
               takenD = 1'b0;
            end
         end
         branch_pkg::S_DEC: begin
            stateD = branch_pkg::S_LIT;
            phaseD = branch_pkg::PH_Q2;
            litD   = instrQ[branch_pkg::OFF_MSB:branch_pkg::OFF_LSB];
         end
         branch_pkg::S_LIT: begin
            stateD = branch_pkg::S_PROC;
            phaseD = branch_pkg::PH_Q3;
         end
         branch_pkg::S_PROC: begin
            // flags are sampled here, in the process phase
            stateD  = branch_pkg::S_WRITE;
            phaseD  = branch_pkg::PH_Q4;
            takenD  = mif.condClear;
            pcWeD   = mif.condClear;
            pcNextD = baseQ + offsetX2;
         end
         branch_pkg::S_WRITE: begin
            phaseD = branch_pkg::PH_Q1;
            if (takenQ) begin
               // the prefetched word is wrong, so a dead cycle follows
               stateD = branch_pkg::S_NOP;
               flushD = 1'b1;
            end else begin
               // pc untouched: fetch carries on sequentially
               stateD = branch_pkg::S_IDLE;
               doneD  = 1'b1;
               readyD = 1'b1;
               busyD  = 1'b0;
            end
         end
         branch_pkg::S_NOP: begin
            phaseD = phaseQ + branch_pkg::PH_STEP;
            if (phaseQ == branch_pkg::PH_Q4) begin
               stateD = branch_pkg::S_IDLE;
               phaseD = branch_pkg::PH_Q1;
               doneD  = 1'b1;
               readyD = 1'b1;
               busyD  = 1'b0;
               flushD = 1'b0;
            end
         end
      endcase
   end

   // state registers; clkEn low freezes everything
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stateQ   <= branch_pkg::S_IDLE;
         instrQ   <= branch_pkg::WORD_RST;
         baseQ    <= branch_pkg::PC_RST;
         litQ     <= branch_pkg::OFF_RST;
         pcNextQ  <= branch_pkg::PC_RST;
         phaseQ   <= branch_pkg::PH_Q1;
         readyQ   <= 1'b1;
         busyQ    <= 1'b0;
         takenQ   <= 1'b0;
         flushQ   <= 1'b0;
         pcWeQ    <= 1'b0;
         doneQ    <= 1'b0;
         flagsWeQ <= 1'b0;
      end else if (clkEn) begin
         stateQ   <= stateD;
         instrQ   <= instrD;
         baseQ    <= baseD;
         litQ     <= litD;
         pcNextQ  <= pcNextD;
         phaseQ   <= phaseD;
         readyQ   <= readyD;
         busyQ    <= busyD;
         takenQ   <= takenD;
         flushQ   <= flushD;
         pcWeQ    <= pcWeD;
         doneQ    <= doneD;
         flagsWeQ <= 1'b0;
      end
   end

   // assertions count enabled clocks only, so a frozen core stays legal
   default clocking cb @(posedge clk iff clkEn);
   endclocking
   default disable iff (!arst_n);

   sequence acceptSeq;
      stateQ == branch_pkg::S_IDLE && instrValid && mif.hit;
   endsequence

   sequence frontPhases;
      stateQ == branch_pkg::S_DEC ##1 stateQ == branch_pkg::S_LIT
         ##1 stateQ == branch_pkg::S_PROC ##1 stateQ == branch_pkg::S_WRITE;
   endsequence

   sequence nopCycle;
      (stateQ == branch_pkg::S_NOP && flushQ && !pcWeQ)[*4];
   endsequence

   a_carry_taken: assert property (
      stateQ == branch_pkg::S_PROC &&
      instrQ[branch_pkg::OPC_MSB:branch_pkg::OPC_LSB] ==
         branch_pkg::OPC_CARRY_CLR
      |=> (takenQ == !$past(carryFlag)) && (pcWeQ == takenQ))
      else $error("carry clear branch decision wrong");

   a_neg_taken: assert property (
      stateQ == branch_pkg::S_PROC &&
      instrQ[branch_pkg::OPC_MSB:branch_pkg::OPC_LSB] ==
         branch_pkg::OPC_NEG_CLR
      |=> takenQ == !$past(negFlag))
      else $error("negative clear branch decision wrong");

   a_ovf_taken: assert property (
      stateQ == branch_pkg::S_PROC &&
      instrQ[branch_pkg::OPC_MSB:branch_pkg::OPC_LSB] ==
         branch_pkg::OPC_OVF_CLR
      |=> takenQ == !$past(ovfFlag))
      else $error("overflow clear branch decision wrong");

   a_pc_target: assert property (
      pcWeQ |-> pcNextQ == baseQ + {{(branch_pkg::PC_W-branch_pkg::OFF_W-1)
         {instrQ[branch_pkg::OFF_MSB]}},
         instrQ[branch_pkg::OFF_MSB:branch_pkg::OFF_LSB], 1'b0})
      else $error("branch target is not base plus twice offset");

   a_front_phases: assert property (
      acceptSeq |=> frontPhases)
      else $error("decode phases out of order");

   a_taken_cycle: assert property (
      stateQ == branch_pkg::S_WRITE && takenQ
      |-> pcWeQ && phaseQ == branch_pkg::PH_Q4 ##1 nopCycle ##1
          (doneQ && readyQ))
      else $error("taken branch not two cycles");

   a_untaken_cycle: assert property (
      stateQ == branch_pkg::S_WRITE && !takenQ
      |-> !pcWeQ ##1 (doneQ && !flushQ && !pcWeQ))
      else $error("not taken branch not one cycle");

   a_flags_kept: assert property (
      busyQ || doneQ |-> !flagsWeQ throughout (##[0:9] doneQ))
      else $error("status flags written by branch");
endmodule

// ==== dv/test_conditional_branch_decode.sv ====
// self-checking bench for the clear-flag conditional branch sequencer
`timescale 1ns/10ps
module test_conditional_branch_decode;
   localparam int LIMIT = 3000; // runs need about 130 cycles
   logic                          clk;
   logic                          arst_n;
   logic                          clkEn;
   logic                          instrValid;
   logic [branch_pkg::WORD_W-1:0] instrWord;
   logic [branch_pkg::PC_W-1:0]   pcIn;
   logic                          carryFlag;
   logic                          negFlag;
   logic                          ovfFlag;
   logic                          readyQ;
   logic                          busyQ;
   logic [1:0]                    phaseQ;
   logic                          pcWeQ;
   logic [branch_pkg::PC_W-1:0]   pcNextQ;
   logic                          takenQ;
   logic                          flushQ;
   logic                          doneQ;
   logic                          flagsWeQ;
   int                            fails;
   int                            checked;
   int                            cycles;

   conditional_branch_decode dut (
      .clk        (clk),
      .arst_n     (arst_n),
      .clkEn      (clkEn),
      .instrValid (instrValid),
      .instrWord  (instrWord),
      .pcIn       (pcIn),
      .carryFlag  (carryFlag),
      .negFlag    (negFlag),
      .ovfFlag    (ovfFlag),
      .readyQ     (readyQ),
      .busyQ      (busyQ),
      .phaseQ     (phaseQ),
      .pcWeQ      (pcWeQ),
      .pcNextQ    (pcNextQ),
      .takenQ     (takenQ),
      .flushQ     (flushQ),
      .doneQ      (doneQ),
      .flagsWeQ   (flagsWeQ)
   );

   // 40 MHz core clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard: a stuck handshake must still reach the verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         fails++;
         summarize();
      end
   end

   task automatic summarize();
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // idle outputs as left by reset, seen only while no branch has been accepted since the last reset
   task automatic idle_check();
      chk({readyQ, busyQ, phaseQ, pcWeQ, takenQ}, 32'h20);
      chk({flushQ, doneQ, flagsWeQ}, 32'h0);
      chk(pcNextQ, 32'h0);
   endtask

   // one branch; offers stay up while busy, so they must be refused
   task automatic run_branch(input int kind, input logic flag,
                             input logic [7:0] off, input logic [20:0] pc);
      logic [20:0] target;
      logic        taken;
      int          last;
      target = pc + {{12{off[7]}}, off, 1'b0};
      taken = !flag;
      last = taken ? 9 : 5;
      instrValid = 1'b1;
      instrWord = {(kind == 0) ? 8'hE3 : (kind == 1) ? 8'hE7 : 8'hE5, off};
      pcIn = pc;
      // only the tested flag carries the decision, others say the opposite
      {ovfFlag, negFlag, carryFlag} = flag ? 3'h1 << kind : ~(3'h1 << kind);
      for (int k = 1; k <= last; k++) begin
         @(negedge clk);
         if (k == 1) begin
            instrWord = {instrWord[15:8], ~off};
            pcIn = ~pc;
         end
         chk({busyQ, readyQ}, (k < last) ? 2 : 1);
         chk(doneQ, k == last);
         chk(phaseQ, (k - 1) % 4);
         chk(pcWeQ, taken && k == 4);
         chk(flushQ, taken && k >= 5 && k < 9);
         chk(flagsWeQ, 1'b0);
         if (k >= 4) chk(takenQ, taken);
         // the target register is refreshed in the process phase either way
         if (k >= 4) chk(pcNextQ, target);
      end
   endtask

   // near-miss upper bytes are not ours and must be ignored
   task automatic foreign_words();
      logic [7:0] opc [5] = '{8'hE6, 8'hE1, 8'hE2, 8'h63, 8'hF3};
      @(negedge clk);
      instrValid = 1'b1;
      carryFlag = 1'b0;
      for (int i = 0; i < 5; i++) begin
         instrWord = {opc[i], 8'h10};
         repeat (2) @(negedge clk);
         chk({readyQ, busyQ, pcWeQ}, 32'h4);
      end
      instrValid = 1'b0;
   endtask

   // clock enable low stalls the phase sequence in place
   task automatic freeze();
      int n;
      @(negedge clk);
      instrValid = 1'b1;
      instrWord = 16'hE3FE;
      pcIn = 21'h000040;
      @(negedge clk);
      instrValid = 1'b0;
      @(negedge clk);
      clkEn = 1'b0;
      repeat (3) @(negedge clk);
      chk({busyQ, phaseQ}, 32'h5);
      clkEn = 1'b1;
      n = 0;
      while (n < 12 && doneQ !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      chk(n, 7);
      chk(pcNextQ, 21'h00003C);
   endtask

   // reset in mid-branch drops it; outputs idle for two edges after release
   task automatic reset_mid();
      @(negedge clk);
      instrValid = 1'b1;
      instrWord = 16'hE710;
      pcIn = 21'h000300;
      negFlag = 1'b0;
      repeat (2) @(negedge clk);
      instrValid = 1'b0;
      arst_n = 1'b0;
      @(negedge clk);
      idle_check();
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      idle_check();
   endtask

   // main sequence
   initial begin
      fails = 0;
      checked = 0;
      cycles = 0;
      arst_n = 1'b0;
      clkEn = 1'b1;
      instrValid = 1'b0;
      instrWord = 16'h0000;
      pcIn = 21'h000000;
      {ovfFlag, negFlag, carryFlag} = 3'h0;
      repeat (12) @(negedge clk);
      idle_check();
      arst_n = 1'b1;
      @(negedge clk);
      idle_check();
      // back to back: each offer after the first lands in the previous finish cycle
      for (int kind = 0; kind < 3; kind++) begin
         run_branch(kind, 1'b0, 8'h7F, 21'h000100);
         run_branch(kind, 1'b1, 8'h80, 21'h000200);
      end
      run_branch(0, 1'b0, 8'h80, 21'h000104);
      run_branch(1, 1'b0, 8'hFF, 21'h000010);
      run_branch(2, 1'b0, 8'h01, 21'h1FFFFE);
      run_branch(2, 1'b0, 8'h00, 21'h000020);
      instrValid = 1'b0;
      foreign_words();
      freeze();
      reset_mid();
      // first offer right after the second release must still be taken
      run_branch(1, 1'b0, 8'h40, 21'h000300);
      summarize();
   end
endmodule
